/* hw/atc_pkg.sv */
/*
 * Shared constants for the threshold, trigger and charge pump block.
 * Assumes an 8-bit register port with byte-wide registers at word indexes.
 */
package atc_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam int VAL_W = 16;
    localparam int CODE_W = 5;
    localparam int SRC_W = 32;

    // Register offsets
    localparam logic [ADDR_W-1:0] OFS_LTH_HI = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_LTH_LO = 4'h1;
    localparam logic [ADDR_W-1:0] OFS_UTH_HI = 4'h2;
    localparam logic [ADDR_W-1:0] OFS_UTH_LO = 4'h3;
    localparam logic [ADDR_W-1:0] OFS_TRIG_SEL = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_PUMP = 4'h5;
    localparam logic [ADDR_W-1:0] OFS_CTRL = 4'h6;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h7;
    localparam logic [ADDR_W-1:0] OFS_CHAN = 4'h8;
    localparam logic [ADDR_W-1:0] OFS_RES_HI = 4'h9;
    localparam logic [ADDR_W-1:0] OFS_ERR_HI = 4'hA;
    localparam logic [ADDR_W-1:0] OFS_ERR_LO = 4'hB;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 4'hC;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 4'hD;

    // Field positions
    localparam int PUMP_EN_BIT = 7;
    localparam int PUMP_RDY_BIT = 0;
    localparam int CTRL_CONV_EN_BIT = 7;
    localparam int CTRL_CALC_LSB = 4;
    localparam int CTRL_TMD_LSB = 0;
    localparam int STAT_ABOVE_BIT = 1;
    localparam int STAT_BELOW_BIT = 0;
    localparam int IRQ_THR_BIT = 0;
    localparam int IRQ_CONV_BIT = 1;
    localparam int IRQ_PUMP_BIT = 2;
    localparam int IRQ_W = 3;

    // Reset values
    localparam logic [DATA_W-1:0] RST_BYTE = 8'h00;
    localparam logic [VAL_W-1:0] RST_WORD = 16'h0000;
    localparam logic [CODE_W-1:0] RST_CODE = 5'h00;
    localparam logic [IRQ_W-1:0] RST_IRQ = 3'h0;

    // Trigger source codes
    localparam logic [CODE_W-1:0] CODE_OFF = 5'h00;
    localparam logic [CODE_W-1:0] CODE_PIN = 5'h01;
    localparam logic [CODE_W-1:0] CODE_HW_LAST = 5'h19;
    localparam logic [CODE_W-1:0] CODE_RD_ERR = 5'h1A;
    localparam logic [CODE_W-1:0] CODE_RD_RES = 5'h1B;
    localparam logic [CODE_W-1:0] CODE_WR_CHAN = 5'h1D;

    typedef enum logic [2:0] {
        TMD_NEVER = 3'h0, TMD_BELOW = 3'h1, TMD_NOT_BELOW = 3'h2, TMD_INSIDE = 3'h3,
        TMD_OUTSIDE = 3'h4, TMD_NOT_ABOVE = 3'h5, TMD_ABOVE = 3'h6, TMD_ALWAYS = 3'h7
    } atc_tmd_e;

    typedef enum logic [2:0] {
        CALC_RES_MINUS_SP = 3'h0, CALC_SP_MINUS_RES = 3'h1, CALC_RAW = 3'h2, CALC_DELTA = 3'h3
    } atc_calc_e;

    function automatic logic is_pin_or_hw(input logic [CODE_W-1:0] code);
        return (code >= CODE_PIN) && (code <= CODE_HW_LAST);
    endfunction
endpackage

/* hw/atc_trig_if.sv */
/*
 * Trigger selection signals between the control core and the selector.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface atc_trig_if;
    logic [atc_pkg::CODE_W-1:0] code;
    logic [atc_pkg::SRC_W-1:0] src;
    logic sw_wr_chan;
    logic sw_rd_res;
    logic sw_rd_err;
    logic fire;
    modport ctl (output code, src, sw_wr_chan, sw_rd_res, sw_rd_err, input fire);
    modport sel (input code, src, sw_wr_chan, sw_rd_res, sw_rd_err, output fire);
endinterface
`default_nettype wire

/* hw/atc_trig_sel.sv */
/*
 * Trigger source selector: picks one synchronised source by code and
 * emits a one-cycle pulse on its rising edge, or on a software access.
 * Assumes the source vector is already synchronised to the clock.
 */
`timescale 1ns/1ps
`default_nettype none
module atc_trig_sel (
    input wire logic clk_in,  // System clock
    input wire logic rst_in,  // Async reset, high
    atc_trig_if.sel trig      // Selection port
);
    import atc_pkg::*;
    logic prev_ff, nxt_prev;
    logic fire_ff, nxt_fire;
    logic cur;

    always_comb begin
        cur = trig.src[trig.code];
        nxt_prev = cur;
        nxt_fire = 1'b0;
        if (is_pin_or_hw(trig.code)) begin
            nxt_fire = cur & ~prev_ff;
        end else begin
            case (trig.code)
                CODE_WR_CHAN: nxt_fire = trig.sw_wr_chan;
                CODE_RD_RES: nxt_fire = trig.sw_rd_res;
                CODE_RD_ERR: nxt_fire = trig.sw_rd_err;
                default: nxt_fire = 1'b0;
            endcase
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            prev_ff <= 1'b0;
            fire_ff <= 1'b0;
        end else begin
            prev_ff <= nxt_prev;
            fire_ff <= nxt_fire;
        end
    end

    assign trig.fire = fire_ff;

    a_off_no_fire: assert property (@(posedge clk_in) disable iff (rst_in)
        (trig.code == CODE_OFF) |=> !trig.fire)
        else $error("Trigger fired with code zero");
    a_hw_edge_fire: assert property (@(posedge clk_in) disable iff (rst_in)
        (is_pin_or_hw(trig.code) && $stable(trig.code) && $rose(trig.src[trig.code])) |=> trig.fire)
        else $error("Selected source edge gave no trigger");
endmodule // atc_trig_sel
`default_nettype wire

/* hw/atc_ctrl.sv */
/*
 * Threshold compare, trigger select and charge pump control for a converter.
 * Assumes one 100 MHz clock, a byte register port, converter results that
 * arrive on the same clock, and trigger sources and pump ready from outside.
 */
// Local design decisions: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module atc_ctrl (
    input wire logic CLOCK_IN,                              // 100 MHz clock
    input wire logic RESET_IN,                              // Async reset, high
    input wire logic [atc_pkg::ADDR_W-1:0] ADDR_IN,         // Register address
    input wire logic [atc_pkg::DATA_W-1:0] WDATA_IN,        // Write data
    input wire logic WR_IN,                                 // Write strobe
    input wire logic RD_IN,                                 // Read strobe
    output logic [atc_pkg::DATA_W-1:0] RDATA_OUT,           // Read data, next cycle
    input wire logic [atc_pkg::SRC_W-1:0] TRIG_SRC_IN,      // Trigger sources by code
    input wire logic [atc_pkg::VAL_W-1:0] RESULT_IN,        // Conversion result
    input wire logic [atc_pkg::VAL_W-1:0] SETPOINT_IN,      // Setpoint
    input wire logic RESULT_VALID_IN,                       // Result strobe
    input wire logic PUMP_REQ_IN,                           // Converter wants pump
    input wire logic PUMP_READY_IN,                         // Pump ready, async
    output logic CONV_START_OUT,                            // Start pulse
    output logic PUMP_ON_OUT,                               // Pump run
    output logic IRQ_OUT                                    // Interrupt level
);
    import atc_pkg::*;

    atc_trig_if trig ();

    logic [VAL_W-1:0] lth_ff, nxt_lth, uth_ff, nxt_uth;
    logic [CODE_W-1:0] code_ff, nxt_code;
    logic pump_en_ff, nxt_pump_en;
    logic conv_en_ff, nxt_conv_en;
    logic [2:0] calc_ff, nxt_calc;
    logic [2:0] tmd_ff, nxt_tmd;
    logic [DATA_W-1:0] chan_ff, nxt_chan;
    logic [VAL_W-1:0] err_ff, nxt_err, prev_res_ff, nxt_prev_res;
    logic above_ff, nxt_above, below_ff, nxt_below;
    logic [IRQ_W-1:0] ist_ff, nxt_ist, imask_ff, nxt_imask;
    logic [DATA_W-1:0] rdata_ff, nxt_rdata;
    logic start_ff, nxt_start, pump_on_ff, nxt_pump_on, irq_ff, nxt_irq;
    logic [SRC_W-1:0] src_s1_ff, src_s2_ff;
    logic rdy_s1_ff, rdy_s2_ff, rdy_old_ff;
    logic wr_hit, rd_hit;
    logic [VAL_W-1:0] err_calc;
    logic cmp_above, cmp_below, thr_event;
    logic [IRQ_W-1:0] ev;

    function automatic logic hit(input logic strobe, input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
        return strobe && (a == ofs);
    endfunction

    // Two-stage synchronisers for outside signals
    always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            src_s1_ff <= '0;
            src_s2_ff <= '0;
            rdy_s1_ff <= 1'b0;
            rdy_s2_ff <= 1'b0;
            rdy_old_ff <= 1'b0;
        end else begin
            src_s1_ff <= TRIG_SRC_IN;
            src_s2_ff <= src_s1_ff;
            rdy_s1_ff <= PUMP_READY_IN;
            rdy_s2_ff <= rdy_s1_ff;
            rdy_old_ff <= rdy_s2_ff;
        end
    end

    assign trig.code = code_ff;
    assign trig.src = src_s2_ff;
    assign trig.sw_wr_chan = hit(WR_IN, ADDR_IN, OFS_CHAN);
    assign trig.sw_rd_res = hit(RD_IN, ADDR_IN, OFS_RES_HI);
    assign trig.sw_rd_err = hit(RD_IN, ADDR_IN, OFS_ERR_HI);

    atc_trig_sel u_sel (
        .clk_in(CLOCK_IN),
        .rst_in(RESET_IN),
        .trig(trig)
    );

    // Error calculation and limit compare, signed
    always_comb begin
        case (calc_ff)
            CALC_SP_MINUS_RES: err_calc = SETPOINT_IN - RESULT_IN;
            CALC_RAW: err_calc = RESULT_IN;
            CALC_DELTA: err_calc = RESULT_IN - prev_res_ff;
            default: err_calc = RESULT_IN - SETPOINT_IN;
        endcase
        cmp_above = $signed(err_calc) > $signed(uth_ff);
        cmp_below = $signed(err_calc) < $signed(lth_ff);
        case (tmd_ff)
            TMD_BELOW: thr_event = cmp_below;
            TMD_NOT_BELOW: thr_event = !cmp_below;
            TMD_INSIDE: thr_event = !cmp_below && !cmp_above;
            TMD_OUTSIDE: thr_event = cmp_below || cmp_above;
            TMD_NOT_ABOVE: thr_event = !cmp_above;
            TMD_ABOVE: thr_event = cmp_above;
            TMD_ALWAYS: thr_event = 1'b1;
            default: thr_event = 1'b0;
        endcase
    end

    always_comb begin
        wr_hit = WR_IN;
        rd_hit = RD_IN;
        nxt_lth = lth_ff;
        nxt_uth = uth_ff;
        nxt_code = code_ff;
        nxt_pump_en = pump_en_ff;
        nxt_conv_en = conv_en_ff;
        nxt_calc = calc_ff;
        nxt_tmd = tmd_ff;
        nxt_chan = chan_ff;
        nxt_imask = imask_ff;
        nxt_err = err_ff;
        nxt_prev_res = prev_res_ff;
        nxt_above = above_ff;
        nxt_below = below_ff;
        if (wr_hit) begin
            case (ADDR_IN)
                OFS_LTH_HI: nxt_lth[15:8] = WDATA_IN;
                OFS_LTH_LO: nxt_lth[7:0] = WDATA_IN;
                OFS_UTH_HI: nxt_uth[15:8] = WDATA_IN;
                OFS_UTH_LO: nxt_uth[7:0] = WDATA_IN;
                OFS_TRIG_SEL: nxt_code = WDATA_IN[CODE_W-1:0];
                OFS_PUMP: nxt_pump_en = WDATA_IN[PUMP_EN_BIT];
                OFS_CTRL: begin
                    nxt_conv_en = WDATA_IN[CTRL_CONV_EN_BIT];
                    nxt_calc = WDATA_IN[CTRL_CALC_LSB +: 3];
                    nxt_tmd = WDATA_IN[CTRL_TMD_LSB +: 3];
                end
                OFS_CHAN: nxt_chan = WDATA_IN;
                OFS_IRQ_MASK: nxt_imask = WDATA_IN[IRQ_W-1:0];
                default: nxt_chan = chan_ff;
            endcase
        end
        if (RESULT_VALID_IN) begin
            nxt_err = err_calc;
            nxt_prev_res = RESULT_IN;
            nxt_above = cmp_above;
            nxt_below = cmp_below;
        end
        nxt_rdata = RST_BYTE;
        if (rd_hit) begin
            case (ADDR_IN)
                OFS_LTH_HI: nxt_rdata = lth_ff[15:8];
                OFS_LTH_LO: nxt_rdata = lth_ff[7:0];
                OFS_UTH_HI: nxt_rdata = uth_ff[15:8];
                OFS_UTH_LO: nxt_rdata = uth_ff[7:0];
                OFS_TRIG_SEL: nxt_rdata = {3'b000, code_ff};
                OFS_PUMP: nxt_rdata = {pump_en_ff, 6'b00_0000, rdy_s2_ff};
                OFS_CTRL: nxt_rdata = {conv_en_ff, calc_ff, 1'b0, tmd_ff};
                OFS_STATUS: nxt_rdata = {6'b00_0000, above_ff, below_ff};
                OFS_CHAN: nxt_rdata = chan_ff;
                OFS_RES_HI: nxt_rdata = RESULT_IN[15:8];
                OFS_ERR_HI: nxt_rdata = err_ff[15:8];
                OFS_ERR_LO: nxt_rdata = err_ff[7:0];
                OFS_IRQ_STAT: nxt_rdata = {5'b0_0000, ist_ff};
                OFS_IRQ_MASK: nxt_rdata = {5'b0_0000, imask_ff};
                default: nxt_rdata = RST_BYTE;
            endcase
        end
    end

    // Events, sticky status with set winning over write-one-clear
    always_comb begin
        nxt_start = conv_en_ff && trig.fire && (code_ff != CODE_OFF);
        ev = RST_IRQ;
        ev[IRQ_THR_BIT] = RESULT_VALID_IN && thr_event;
        ev[IRQ_CONV_BIT] = nxt_start;
        ev[IRQ_PUMP_BIT] = rdy_s2_ff && !rdy_old_ff;
        nxt_ist = ist_ff;
        if (hit(WR_IN, ADDR_IN, OFS_IRQ_STAT)) begin
            nxt_ist = ist_ff & ~WDATA_IN[IRQ_W-1:0];
        end
        nxt_ist = nxt_ist | ev;
        nxt_irq = |(nxt_ist & nxt_imask);
        nxt_pump_on = pump_en_ff && PUMP_REQ_IN;
    end

    always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            lth_ff <= RST_WORD;
            uth_ff <= RST_WORD;
            code_ff <= RST_CODE;
            pump_en_ff <= 1'b0;
            conv_en_ff <= 1'b0;
            calc_ff <= 3'h0;
            tmd_ff <= 3'h0;
            chan_ff <= RST_BYTE;
            imask_ff <= RST_IRQ;
            ist_ff <= RST_IRQ;
            err_ff <= RST_WORD;
            prev_res_ff <= RST_WORD;
            above_ff <= 1'b0;
            below_ff <= 1'b0;
            rdata_ff <= RST_BYTE;
            start_ff <= 1'b0;
            pump_on_ff <= 1'b0;
            irq_ff <= 1'b0;
        end else begin
            lth_ff <= nxt_lth;
            uth_ff <= nxt_uth;
            code_ff <= nxt_code;
            pump_en_ff <= nxt_pump_en;
            conv_en_ff <= nxt_conv_en;
            calc_ff <= nxt_calc;
            tmd_ff <= nxt_tmd;
            chan_ff <= nxt_chan;
            imask_ff <= nxt_imask;
            ist_ff <= nxt_ist;
            err_ff <= nxt_err;
            prev_res_ff <= nxt_prev_res;
            above_ff <= nxt_above;
            below_ff <= nxt_below;
            rdata_ff <= nxt_rdata;
            start_ff <= nxt_start;
            pump_on_ff <= nxt_pump_on;
            irq_ff <= nxt_irq;
        end
    end

    assign RDATA_OUT = rdata_ff;
    assign CONV_START_OUT = start_ff;
    assign PUMP_ON_OUT = pump_on_ff;
    assign IRQ_OUT = irq_ff;

    default clocking cb @(posedge CLOCK_IN); endclocking
    default disable iff (RESET_IN);

    sequence s_chan_write;
        conv_en_ff && (code_ff == CODE_WR_CHAN) && WR_IN && (ADDR_IN == OFS_CHAN);
    endsequence
    sequence s_res_read;
        conv_en_ff && (code_ff == CODE_RD_RES) && RD_IN && (ADDR_IN == OFS_RES_HI);
    endsequence
    sequence s_err_read;
        conv_en_ff && (code_ff == CODE_RD_ERR) && RD_IN && (ADDR_IN == OFS_ERR_HI);
    endsequence
    sequence s_pin_rise;
        conv_en_ff && (code_ff == CODE_PIN) && $stable(code_ff) && $rose(src_s2_ff[CODE_PIN]);
    endsequence

    a_thr_above_flag: assert property (RESULT_VALID_IN && ($signed(err_calc) > $signed(uth_ff))
        |=> above_ff && (err_ff == $past(err_calc)))
        else $error("Above flag not set for error over upper limit");
    a_thr_never_irq: assert property ($rose(ist_ff[IRQ_THR_BIT]) |-> $past(tmd_ff) != TMD_NEVER)
        else $error("Threshold status set in never mode");
    a_lth_write_back: assert property (WR_IN && (ADDR_IN == OFS_LTH_HI) ##1 RD_IN && (ADDR_IN == OFS_LTH_HI)
        |=> RDATA_OUT == $past(WDATA_IN, 2))
        else $error("Lower limit high byte does not read back");
    a_code_upper_zero: assert property (RD_IN && (ADDR_IN == OFS_TRIG_SEL) |=> RDATA_OUT[7:5] == 3'b000)
        else $error("Trigger select upper bits not zero");
    a_chan_write_start: assert property (s_chan_write ##1 conv_en_ff |=> CONV_START_OUT)
        else $error("Channel write did not start conversion");
    a_res_read_start: assert property (s_res_read ##1 conv_en_ff |=> CONV_START_OUT)
        else $error("Result read did not start conversion");
    a_pump_gated_off: assert property (!pump_en_ff |=> !PUMP_ON_OUT)
        else $error("Pump on while disabled");
    a_pump_follow_req: assert property (pump_en_ff && PUMP_REQ_IN |=> PUMP_ON_OUT)
        else $error("Pump not on when enabled and requested");
    a_pump_ready_read: assert property (RD_IN && (ADDR_IN == OFS_PUMP) |=> RDATA_OUT[0] == $past(rdy_s2_ff))
        else $error("Pump ready bit wrong");
    a_off_no_start: assert property ((code_ff == CODE_OFF) [*2] |=> !CONV_START_OUT)
        else $error("Start with trigger disabled");
    a_err_read_start: assert property (s_err_read ##1 conv_en_ff |=> CONV_START_OUT)
        else $error("Error read did not start conversion");
    a_pin_edge_start: assert property (s_pin_rise ##1 conv_en_ff && (code_ff == CODE_PIN)
        |=> CONV_START_OUT)
        else $error("Pin edge did not start conversion");
    a_thr_below_flag: assert property (RESULT_VALID_IN && ($signed(err_calc) < $signed(lth_ff))
        |=> below_ff)
        else $error("Below flag not set for error under lower limit");
    a_thr_above_clear: assert property (RESULT_VALID_IN && !($signed(err_calc) > $signed(uth_ff))
        |=> !above_ff)
        else $error("Above flag set for error within upper limit");
    a_thr_above_irq: assert property (RESULT_VALID_IN && (tmd_ff == TMD_ABOVE)
        && ($signed(err_calc) > $signed(uth_ff)) |=> ist_ff[IRQ_THR_BIT])
        else $error("Threshold status not set in above mode");
    a_irq_out_level: assert property (IRQ_OUT == (|(ist_ff & imask_ff)))
        else $error("Interrupt level does not match unmasked status");
    a_trig_code_write: assert property (WR_IN && (ADDR_IN == OFS_TRIG_SEL)
        |=> code_ff == $past(WDATA_IN[CODE_W-1:0]))
        else $error("Trigger code write not taken");
    a_err_raw_mode: assert property (RESULT_VALID_IN && (calc_ff == CALC_RAW)
        |=> err_ff == $past(RESULT_IN))
        else $error("Raw mode error value wrong");
endmodule // atc_ctrl
`default_nettype wire

/* tb/atc_src_model.sv */
/*
 * Model of the on-chip trigger sources and the charge pump beside the block.
 * Assumes the bench commands each source pulse and that the pump settles a fixed time after it is switched on.
 */
`timescale 1ns/1ps
`default_nettype none
module atc_src_model #(
    parameter int READY_DLY = 6  // Pump settle cycles
) (
    input wire logic clk_in,         // System clock
    input wire logic rst_in,         // Async reset, high
    input wire logic pulse_in,       // Raise one source
    input wire logic [4:0] code_in,  // Source to raise
    input wire logic pump_on_in,     // Pump run level
    output logic [31:0] src_out,     // Source levels
    output logic ready_out           // Pump ready level
);
    logic [1:0] hold_ff, nxt_hold;
    logic [4:0] code_ff, nxt_code;
    logic [3:0] cnt_ff, nxt_cnt;
    always_comb begin
        nxt_hold = pulse_in ? 2'h3 : ((hold_ff != 2'h0) ? hold_ff - 2'h1 : hold_ff);
        nxt_code = pulse_in ? code_in : code_ff;
        nxt_cnt = !pump_on_in ? 4'h0 : ((cnt_ff < 4'(READY_DLY)) ? cnt_ff + 4'h1 : cnt_ff);
    end
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            hold_ff <= 2'h0;
            code_ff <= 5'h00;
            cnt_ff <= 4'h0;
        end else begin
            hold_ff <= nxt_hold;
            code_ff <= nxt_code;
            cnt_ff <= nxt_cnt;
        end
    end
    // Level held three cycles so the synchroniser sees one clean rise
    assign src_out = (hold_ff != 2'h0) ? (32'h0000_0001 << code_ff) : 32'h0000_0000;
    // Pump ready drops on the first clock edge after the pump stops
    assign ready_out = (cnt_ff == 4'(READY_DLY));
endmodule // atc_src_model
`default_nettype wire

/* tb/atc_ctrl_bench.sv */
/*
 * Self-checking bench for the threshold, trigger and charge pump block.
 * Assumes the register map and encodings of the package and a source model beside the design.
 */
`timescale 1ns/1ps
`default_nettype none
module atc_ctrl_bench;
    import atc_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [ADDR_W-1:0] addr = '0;
    logic [DATA_W-1:0] wdata = '0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [VAL_W-1:0] res = '0;
    logic [VAL_W-1:0] spt = '0;
    logic vld = 1'b0;
    logic preq = 1'b0;
    logic pulse = 1'b0;
    logic [CODE_W-1:0] pcode = '0;
    logic [DATA_W-1:0] rdata;
    logic [SRC_W-1:0] src;
    logic prdy, start, pon, irq;
    int err_count = 0;
    int checks = 0;
    int starts = 0;
    int cycles = 0;
    logic [VAL_W-1:0] exp_err = '0;
    logic [31:0] seed = 32'h0000_003C;
    always #5 clk = ~clk;
    atc_ctrl DUT (.CLOCK_IN(clk), .RESET_IN(rst), .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd),
        .RDATA_OUT(rdata), .TRIG_SRC_IN(src), .RESULT_IN(res), .SETPOINT_IN(spt), .RESULT_VALID_IN(vld),
        .PUMP_REQ_IN(preq), .PUMP_READY_IN(prdy), .CONV_START_OUT(start), .PUMP_ON_OUT(pon), .IRQ_OUT(irq));
    atc_src_model #(.READY_DLY(6)) model (.clk_in(clk), .rst_in(rst), .pulse_in(pulse), .code_in(pcode),
        .pump_on_in(pon), .src_out(src), .ready_out(prdy));
    task automatic summarize();
        if (err_count == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Start counter and hang guard
    always @(posedge clk) begin
        cycles++;
        if (start === 1'b1) starts++;
        if (cycles == 20000) begin
            err_count++;
            summarize();
        end
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic hit(input logic [2:0] m, input logic ab, input logic be);
        case (m)
            3'h0: return 1'b0;
            3'h1: return be;
            3'h2: return !be;
            3'h3: return !ab && !be;
            3'h4: return ab || be;
            3'h5: return !ab;
            3'h6: return ab;
            default: return 1'b1;
        endcase
    endfunction
    task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic chk1(input string n, input logic e, input logic g);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("BAD %s exp %b got %b", n, e, g);
        end
    endtask
    task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rdchk(input string n, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk8(n, e, rdata);
    endtask
    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask
    // Select a code, then cause one event: 0 channel write, 1 result read, 2 error read, 3 source pulse
    task automatic act(input logic [4:0] c, input int k, input logic [4:0] p, input int n);
        int s0;
        wr_reg(OFS_TRIG_SEL, {3'h0, c});
        s0 = starts;
        case (k)
            0: wr_reg(OFS_CHAN, 8'(rnd()));
            1: rdchk("res_hi", OFS_RES_HI, res[15:8]);
            2: rdchk("err_hi", OFS_ERR_HI, exp_err[15:8]);
            default: begin
                @(posedge clk);
                pulse <= 1'b1;
                pcode <= p;
                @(posedge clk);
                pulse <= 1'b0;
            end
        endcase
        repeat (10) @(posedge clk);
        chk8("starts", 8'(n), 8'(starts - s0));
    endtask
    initial begin
        logic [15:0] lo, up, r, s, e, pr;
        logic ab, be, h;
        logic [2:0] cm;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        for (int a = 0; a < 16; a++) rdchk("reset", 4'(a), 8'h00);
        for (int a = 0; a < 4; a++) begin
            r[7:0] = 8'(rnd());
            @(posedge clk);
            addr <= 4'(a);
            wdata <= r[7:0];
            wr <= 1'b1;
            @(posedge clk);
            wr <= 1'b0;
            rd <= 1'b1;
            @(posedge clk);
            rd <= 1'b0;
            #1 chk8("limit", r[7:0], rdata);
        end
        wr_reg(OFS_TRIG_SEL, 8'hF9);
        rdchk("code", OFS_TRIG_SEL, 8'h19);
        wr_reg(OFS_PUMP, 8'hFF);
        rdchk("pump", OFS_PUMP, 8'h80);
        wr_reg(4'hF, 8'hA5);
        rdchk("unmapped", 4'hF, 8'h00);
        // Second reset in mid-run
        @(posedge clk);
        rst <= 1'b1;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        for (int a = 0; a < 6; a++) rdchk("rereset", 4'(a), 8'h00);
        pr = 16'h0000;
        wr_reg(OFS_IRQ_MASK, 8'h01);
        for (int i = 0; i < 24; i++) begin
            cm = (i < 3) ? 3'h2 : 3'(i % 4);
            lo = 16'(rnd());
            up = 16'(rnd());
            wr_reg(OFS_LTH_HI, lo[15:8]);
            wr_reg(OFS_LTH_LO, lo[7:0]);
            wr_reg(OFS_UTH_HI, up[15:8]);
            wr_reg(OFS_UTH_LO, up[7:0]);
            wr_reg(OFS_CTRL, {1'b0, cm, 1'b0, 3'(i)});
            wr_reg(OFS_IRQ_STAT, 8'h07);
            r = (i == 0) ? up : ((i == 1) ? lo : 16'(rnd()));
            s = 16'(rnd());
            e = (cm == 3'h0) ? r - s : ((cm == 3'h1) ? s - r : ((cm == 3'h2) ? r : r - pr));
            pr = r;
            exp_err = e;
            ab = $signed(e) > $signed(up);
            be = $signed(e) < $signed(lo);
            h = hit(3'(i), ab, be);
            @(posedge clk);
            res <= r;
            spt <= s;
            vld <= 1'b1;
            @(posedge clk);
            vld <= 1'b0;
            rdchk("flags", OFS_STATUS, {6'h00, ab, be});
            rdchk("err_hi", OFS_ERR_HI, e[15:8]);
            rdchk("err_lo", OFS_ERR_LO, e[7:0]);
            rdchk("irq_stat", OFS_IRQ_STAT, {7'h00, h});
            chk1("irq", h, irq);
        end
        wr_reg(OFS_CTRL, 8'h80);
        for (int c = 1; c < 26; c++) act(5'(c), 3, 5'(c), 1);
        act(5'h03, 3, 5'h04, 0);
        act(CODE_OFF, 3, CODE_PIN, 0);
        act(CODE_WR_CHAN, 0, 5'h00, 1);
        act(CODE_RD_RES, 1, 5'h00, 1);
        act(CODE_RD_ERR, 2, 5'h00, 1);
        act(CODE_RD_RES, 0, 5'h00, 0);
        act(CODE_WR_CHAN, 2, 5'h00, 0);
        wr_reg(OFS_CTRL, 8'h00);
        act(CODE_WR_CHAN, 0, 5'h00, 0);
        rdchk("irq_stat", OFS_IRQ_STAT, 8'h03);
        wr_reg(OFS_IRQ_STAT, 8'h07);
        wr_reg(OFS_IRQ_MASK, 8'h04);
        @(posedge clk);
        preq <= 1'b1;
        settle();
        chk1("pump_on", 1'b0, pon);
        wr_reg(OFS_PUMP, 8'h80);
        settle();
        chk1("pump_on", 1'b1, pon);
        repeat (12) @(posedge clk);
        rdchk("pump", OFS_PUMP, 8'h81);
        chk1("irq", 1'b1, irq);
        wr_reg(OFS_IRQ_MASK, 8'h00);
        settle();
        chk1("irq", 1'b0, irq);
        wr_reg(OFS_IRQ_MASK, 8'h04);
        wr_reg(OFS_IRQ_STAT, 8'h04);
        settle();
        chk1("irq", 1'b0, irq);
        @(posedge clk);
        preq <= 1'b0;
        settle();
        chk1("pump_on", 1'b0, pon);
        repeat (4) @(posedge clk);
        rdchk("pump", OFS_PUMP, 8'h80);
        summarize();
    end
endmodule // atc_ctrl_bench
`default_nettype wire
